/* File: core/cfg_loader_pkg.sv */
// Constants, states and defaults for the configuration loader.
// Assumes one 50 MHz core clock; oscillators arrive as pins.
`default_nettype none

package cfg_loader_pkg;

  // Staged store geometry: ten banks of 26 bits
  localparam int BANKS = 10;
  localparam int WORD_W = 26;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'h9;
  localparam logic [9:0] FUSE_LOAD_ALL = 10'h3ff;

  // Target address field in word 0
  localparam logic [IDX_W-1:0] CFG_WORD = 4'h0;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 2;
  localparam int BTN_MODE_BIT = 3;
  localparam logic ADDR_BIT3 = 1'b1;
  localparam logic [2:0] ADDR_UPPER = 3'h0;
  localparam logic [6:0] ADDR_MIN = 7'h08;
  localparam logic [6:0] ADDR_MAX = 7'h0f;

  // Factory default contents
  localparam logic [WORD_W-1:0] DEF_CFG = 26'h0000000;
  localparam logic [WORD_W-1:0] DEF_OTHER = 26'h0000001;

  // Oscillator trim
  localparam int TRIM_W = 6;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h20;

  // Clock rates and divisions
  localparam int FAST_OSC_HZ = 16000000;
  localparam int SLOW_TICK_HZ = 32000;
  localparam int SW_CLK_HZ = 2000000;
  localparam int DIV32 = FAST_OSC_HZ / SLOW_TICK_HZ;
  localparam int DIV_SW_HALF = FAST_OSC_HZ / SW_CLK_HZ / 2;
  localparam logic [8:0] DIV32_LAST = 9'(DIV32 - 1);
  localparam logic [1:0] SW_LAST = 2'(DIV_SW_HALF - 1);

  // Long button press
  localparam int HOLD_TIME_MS = 4000;
  localparam int HOLD_TICKS = HOLD_TIME_MS * (SLOW_TICK_HZ / 1000);

  // Synchronised pin positions
  localparam int PIN_N = 6;
  localparam int P_VIN = 0;
  localparam int P_SEL = 1;
  localparam int P_BTN = 2;
  localparam int P_UV = 3;
  localparam int P_FAST = 4;
  localparam int P_SLOW = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CLEAR = 3'h1,
    ST_SELECT = 3'h2,
    ST_LOAD_DEF = 3'h3,
    ST_LOAD_FUSE = 3'h4,
    ST_READY = 3'h5
  } load_state_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_FUSE = 2'h1,
    SRC_STAGED = 2'h2,
    SRC_DEFAULT = 2'h3
  } cfg_src_e;

  function automatic logic [WORD_W-1:0] default_word(
      input logic [IDX_W-1:0] idx);
    default_word = (idx == CFG_WORD) ? DEF_CFG : DEF_OTHER;
  endfunction : default_word

endpackage : cfg_loader_pkg

`default_nettype wire

/* File: core/staged_mem.sv */
// Staged configuration store, one write and one read port.
// Assumes writer keeps addresses inside the bank range.
`timescale 1ns/1ps
`default_nettype none

module staged_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [cfg_loader_pkg::IDX_W-1:0] wr_addr,
  input wire logic [cfg_loader_pkg::WORD_W-1:0] wr_data,
  input wire logic [cfg_loader_pkg::IDX_W-1:0] rd_addr,
  output logic [cfg_loader_pkg::WORD_W-1:0] rd_data
);

  logic [cfg_loader_pkg::WORD_W-1:0] mem [0:cfg_loader_pkg::BANKS-1];
  wire rd_ok = rd_addr <= cfg_loader_pkg::LAST_IDX;
  wire wr_ok = wr_addr <= cfg_loader_pkg::LAST_IDX;

  // Storage array
  always_ff @(posedge clk) begin
    if (wr_en && wr_ok) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read, zero outside the banks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_ok ? mem[rd_addr] : '0;
    end
  end

endmodule : staged_mem

`default_nettype wire

/* File: core/otp_config_source_loader.sv */
// Power-up configuration loader: clear, pick source, fill store; a kept start skips all three.
// Assumes pins are asynchronous and control ports are on MCLK.
`timescale 1ns/1ps
`default_nettype none

module otp_config_source_loader #(
  parameter int HOLD_TICKS = cfg_loader_pkg::HOLD_TICKS
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic VIN_VALID,
  input wire logic SUPPLY_SELECT_PIN,
  input wire logic POWER_BUTTON,
  input wire logic VIN_ABOVE_UV,
  input wire logic FAST_OSC,
  input wire logic SLOW_OSC,
  input wire logic ALL_SLEEP,
  input wire logic ALL_PFM,
  input wire logic ON_STATE,
  input wire logic CTRL_WR,
  input wire logic CTRL_KEEP_STAGED_CONFIG,
  input wire logic CTRL_FUSE_LOAD_SELECT,
  input wire logic CTRL_ECC_SELECT,
  input wire logic [9:0] CTRL_FUSE_LOAD_BITS,
  input wire logic TRIM_WR,
  input wire logic [cfg_loader_pkg::TRIM_W-1:0] TRIM_WDATA,
  output logic [cfg_loader_pkg::TRIM_W-1:0] TRIM_CODE,
  input wire logic HOST_WR,
  input wire logic [cfg_loader_pkg::IDX_W-1:0] HOST_ADDR,
  input wire logic [cfg_loader_pkg::WORD_W-1:0] HOST_WDATA,
  output logic FUSE_RD_EN,
  output logic [cfg_loader_pkg::IDX_W-1:0] FUSE_RD_BANK,
  input wire logic [cfg_loader_pkg::WORD_W-1:0] FUSE_RAW_DATA,
  input wire logic [cfg_loader_pkg::WORD_W-1:0] FUSE_CORR_DATA,
  input wire logic FUSE_ECC_PROGRAMMED,
  input wire logic [cfg_loader_pkg::IDX_W-1:0] SEQ_RD_ADDR,
  output logic [cfg_loader_pkg::WORD_W-1:0] SEQ_RD_DATA,
  output logic CONFIG_READY,
  output logic [1:0] CONFIG_SOURCE,
  output logic [3:0] TARGET_ADDR_FIELD,
  output logic [6:0] TARGET_ADDR,
  output logic POWER_BUTTON_MODE,
  output logic START_SEQ,
  output logic TURN_OFF,
  output logic TIMEBASE_TICK,
  output logic DEBOUNCE_TICK,
  output logic IRQ_DEBOUNCE_TICK,
  output logic LOW_INPUT_IRQ_TICK,
  output logic POWER_BUTTON_IRQ_TICK,
  output logic SWITCH_CLK
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int N = cfg_loader_pkg::PIN_N;
  logic [N-1:0] s1;
  logic [N-1:0] s2;
  logic [N-1:0] s3;
  logic [N-1:0] pin;
  logic [N-1:0] pin_q;

  wire [N-1:0] pin_raw = {SLOW_OSC, FAST_OSC, VIN_ABOVE_UV,
                          POWER_BUTTON, SUPPLY_SELECT_PIN, VIN_VALID};
  wire [N-1:0] agree = ~(s2 ^ s3);

  // Three stages, change taken once second and third agree
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin <= '0;
      pin_q <= '0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      pin <= (s3 & agree) | (pin & ~agree);
      pin_q <= pin;
    end
  end

  wire vin = pin[cfg_loader_pkg::P_VIN];
  wire sel_pin = pin[cfg_loader_pkg::P_SEL];
  wire btn = pin[cfg_loader_pkg::P_BTN];
  wire vin_rise = vin & ~pin_q[cfg_loader_pkg::P_VIN];
  wire btn_rise = btn & ~pin_q[cfg_loader_pkg::P_BTN];
  wire btn_fall = ~btn & pin_q[cfg_loader_pkg::P_BTN];
  // Fast oscillator levels last only one or two samples: edge from stages
  wire fast_rise = s2[cfg_loader_pkg::P_FAST] &
                   ~s3[cfg_loader_pkg::P_FAST];
  wire slow_rise = pin[cfg_loader_pkg::P_SLOW] &
                   ~pin_q[cfg_loader_pkg::P_SLOW];

  ////////////////////////////////////////////////////////////////////
  // Load control bits and trim

  logic keep;
  logic fuse_sel;
  logic ecc_sel;
  logic [9:0] load_bits;

  // Keep bit comes up clear after reset
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      keep <= 1'b0;
      fuse_sel <= 1'b0;
      ecc_sel <= 1'b0;
      load_bits <= '0;
    end else if (CTRL_WR) begin
      keep <= CTRL_KEEP_STAGED_CONFIG;
      fuse_sel <= CTRL_FUSE_LOAD_SELECT;
      ecc_sel <= CTRL_ECC_SELECT;
      load_bits <= CTRL_FUSE_LOAD_BITS;
    end
  end

  // Writable oscillator trim
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      TRIM_CODE <= cfg_loader_pkg::TRIM_RESET;
    end else if (TRIM_WR) begin
      TRIM_CODE <= TRIM_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Load sequencer

  cfg_loader_pkg::load_state_e state;
  cfg_loader_pkg::load_state_e next_state;
  cfg_loader_pkg::cfg_src_e src;
  cfg_loader_pkg::cfg_src_e next_src;
  logic [cfg_loader_pkg::IDX_W-1:0] idx;
  logic fuse_pend;
  logic [cfg_loader_pkg::IDX_W-1:0] fuse_widx;

  wire at_last = idx == cfg_loader_pkg::LAST_IDX;
  wire fuses_armed = fuse_sel &
                     (load_bits == cfg_loader_pkg::FUSE_LOAD_ALL);
  wire keep_path = ~sel_pin & keep;
  wire use_corr = ecc_sel & FUSE_ECC_PROGRAMMED;

  // Source picked once, right after the clear
  assign next_src =
    sel_pin ? cfg_loader_pkg::SRC_DEFAULT :
    keep ? cfg_loader_pkg::SRC_STAGED :
    fuses_armed ? cfg_loader_pkg::SRC_FUSE :
    cfg_loader_pkg::SRC_NONE;

  // Next state decode
  always_comb begin
    next_state = state;
    unique case (state)
      cfg_loader_pkg::ST_IDLE: begin
        if (vin_rise && keep_path) begin
          next_state = cfg_loader_pkg::ST_READY;
        end else if (vin_rise) begin
          next_state = cfg_loader_pkg::ST_CLEAR;
        end
      end
      cfg_loader_pkg::ST_CLEAR: begin
        if (at_last) begin
          next_state = cfg_loader_pkg::ST_SELECT;
        end
      end
      cfg_loader_pkg::ST_SELECT: begin
        unique case (next_src)
          cfg_loader_pkg::SRC_DEFAULT:
            next_state = cfg_loader_pkg::ST_LOAD_DEF;
          cfg_loader_pkg::SRC_FUSE:
            next_state = cfg_loader_pkg::ST_LOAD_FUSE;
          cfg_loader_pkg::SRC_STAGED,
          cfg_loader_pkg::SRC_NONE:
            next_state = cfg_loader_pkg::ST_READY;
        endcase
      end
      cfg_loader_pkg::ST_LOAD_DEF: begin
        if (at_last) begin
          next_state = cfg_loader_pkg::ST_READY;
        end
      end
      cfg_loader_pkg::ST_LOAD_FUSE: begin
        if (fuse_pend && fuse_widx == cfg_loader_pkg::LAST_IDX) begin
          next_state = cfg_loader_pkg::ST_READY;
        end
      end
      cfg_loader_pkg::ST_READY: begin
      end
      default: begin
        next_state = cfg_loader_pkg::ST_IDLE;
      end
    endcase
    if (!vin) begin
      next_state = cfg_loader_pkg::ST_IDLE;
    end
  end

  wire issue_rd = (state == cfg_loader_pkg::ST_LOAD_FUSE) &
                  ~(fuse_pend & (fuse_widx == idx));

  // State, source and bank index
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= cfg_loader_pkg::ST_IDLE;
      src <= cfg_loader_pkg::SRC_NONE;
      idx <= '0;
    end else begin
      state <= next_state;
      if (state == cfg_loader_pkg::ST_SELECT) begin
        src <= next_src;
      end else if (state == cfg_loader_pkg::ST_IDLE && vin_rise) begin
        src <= cfg_loader_pkg::SRC_STAGED;
      end
      if (next_state != state) begin
        idx <= '0;
      end else if (!at_last) begin
        idx <= idx + 4'h1;
      end
    end
  end

  // Fuse bank read, data written one cycle later
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      fuse_pend <= 1'b0;
      fuse_widx <= '0;
    end else begin
      fuse_pend <= issue_rd & vin;
      fuse_widx <= idx;
    end
  end

  assign FUSE_RD_EN = issue_rd & vin;
  assign FUSE_RD_BANK = idx;

  ////////////////////////////////////////////////////////////////////
  // Staged store write port

  wire in_ready = state == cfg_loader_pkg::ST_READY;
  wire wr_clear = state == cfg_loader_pkg::ST_CLEAR;
  wire wr_def = state == cfg_loader_pkg::ST_LOAD_DEF;
  wire wr_host = in_ready & vin & HOST_WR &
                 (HOST_ADDR <= cfg_loader_pkg::LAST_IDX);
  wire [cfg_loader_pkg::WORD_W-1:0] fuse_word =
    use_corr ? FUSE_CORR_DATA : FUSE_RAW_DATA;

  wire mem_wr = wr_clear | wr_def | fuse_pend | wr_host;
  wire [cfg_loader_pkg::IDX_W-1:0] mem_waddr =
    fuse_pend ? fuse_widx : (wr_host ? HOST_ADDR : idx);
  wire [cfg_loader_pkg::WORD_W-1:0] mem_wdata =
    wr_clear ? '0 :
    wr_def ? cfg_loader_pkg::default_word(idx) :
    fuse_pend ? fuse_word :
    HOST_WDATA;

  staged_mem u_mem (
    .clk(MCLK),
    .rst_n(RESETN),
    .wr_en(mem_wr),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(SEQ_RD_ADDR),
    .rd_data(SEQ_RD_DATA)
  );

  // Sequencer may read only after the load finished
  assign CONFIG_READY = in_ready;
  assign CONFIG_SOURCE = src;

  ////////////////////////////////////////////////////////////////////
  // Shadow of word 0: target address and button mode

  logic [2:0] addr_low;
  wire cfg_wr = mem_wr & (mem_waddr == cfg_loader_pkg::CFG_WORD);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_low <= '0;
      POWER_BUTTON_MODE <= 1'b0;
    end else if (cfg_wr) begin
      addr_low <= mem_wdata[cfg_loader_pkg::ADDR_MSB:
                            cfg_loader_pkg::ADDR_LSB];
      POWER_BUTTON_MODE <= mem_wdata[cfg_loader_pkg::BTN_MODE_BIT];
    end
  end

  // Bit 3 forced, low bits map straight through
  assign TARGET_ADDR_FIELD = {cfg_loader_pkg::ADDR_BIT3,
                              addr_low};
  assign TARGET_ADDR = {cfg_loader_pkg::ADDR_UPPER,
                        TARGET_ADDR_FIELD};

  ////////////////////////////////////////////////////////////////////
  // Clock ticks

  logic [8:0] div32;
  logic [1:0] div_sw;
  logic fast_tick;
  logic slow_tick;

  // Divide fast oscillator edges to 32 kHz and 2 MHz
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      div32 <= '0;
      div_sw <= '0;
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
      SWITCH_CLK <= 1'b0;
    end else begin
      slow_tick <= slow_rise;
      fast_tick <= fast_rise & (div32 == cfg_loader_pkg::DIV32_LAST);
      if (fast_rise) begin
        div32 <= (div32 == cfg_loader_pkg::DIV32_LAST) ?
                 '0 : div32 + 9'h1;
        div_sw <= div_sw + 2'h1;
        if (div_sw == cfg_loader_pkg::SW_LAST) begin
          SWITCH_CLK <= ~SWITCH_CLK;
        end
      end
    end
  end

  // Timebase untrimmed only in its three cases; low-input and button IRQ ticks always untrimmed
  wire use_slow = ~pin[cfg_loader_pkg::P_UV] |
                  ALL_SLEEP | ALL_PFM;
  assign TIMEBASE_TICK = use_slow ? slow_tick : fast_tick;
  assign DEBOUNCE_TICK = POWER_BUTTON_MODE ?
                         fast_tick : TIMEBASE_TICK;
  assign IRQ_DEBOUNCE_TICK = (ON_STATE & ~use_slow) ?
                             fast_tick : slow_tick;
  assign LOW_INPUT_IRQ_TICK = slow_tick;
  assign POWER_BUTTON_IRQ_TICK = slow_tick;

  ////////////////////////////////////////////////////////////////////
  // Power button and start request

  // First tick after the press is partial, so one extra tick is counted
  localparam logic [16:0] HOLD_LAST = 17'(HOLD_TICKS);
  logic [16:0] hold_cnt;
  logic held;

  wire edge_mode = POWER_BUTTON_MODE;
  wire turn_on = edge_mode ? btn_fall : btn_rise;
  wire eff_staged = keep_path;
  wire start_ok = in_ready & vin &
                  (eff_staged | (src != cfg_loader_pkg::SRC_NONE));

  // Count debounce ticks while held low in edge mode
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_cnt <= '0;
      held <= 1'b0;
    end else if (!edge_mode || btn) begin
      hold_cnt <= '0;
      held <= 1'b0;
    end else if (DEBOUNCE_TICK && !held) begin
      hold_cnt <= hold_cnt + 17'h1;
      held <= hold_cnt == HOLD_LAST;
    end
  end

  // One-cycle start and stop requests
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      START_SEQ <= 1'b0;
      TURN_OFF <= 1'b0;
    end else begin
      START_SEQ <= turn_on & start_ok;
      TURN_OFF <= edge_mode ?
                  (DEBOUNCE_TICK & ~held & edge_mode & ~btn &
                   (hold_cnt == HOLD_LAST)) :
                  btn_fall;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  // Bit 3 stays one, low bits follow the last word 0 write
  a_addr_bit3: assert property (@(posedge MCLK) disable iff (!RESETN)
    cfg_wr |=> TARGET_ADDR_FIELD == {cfg_loader_pkg::ADDR_BIT3,
      $past(mem_wdata[cfg_loader_pkg::ADDR_MSB:
                      cfg_loader_pkg::ADDR_LSB])})
    else $error("address field not loaded from word 0");

  a_addr_range: assert property (@(posedge MCLK) disable iff (!RESETN)
    TARGET_ADDR >= 7'h08 && TARGET_ADDR <= 7'h0f)
    else $error("target address out of range");

  a_clear_first: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    $rose(state == cfg_loader_pkg::ST_SELECT) |->
      $past(state == cfg_loader_pkg::ST_CLEAR, 1) &&
      $past(mem_wr && mem_wdata == '0, 1))
    else $error("select without clear");

  a_default_load: assert property (@(posedge MCLK)
    disable iff (!RESETN)
    (state == cfg_loader_pkg::ST_SELECT && sel_pin && vin) |=>
      state == cfg_loader_pkg::ST_LOAD_DEF)
    else $error("default not loaded");

  a_fuse_load: assert property (@(posedge MCLK) disable iff (!RESETN)
    (state == cfg_loader_pkg::ST_SELECT && !sel_pin && !keep &&
     fuses_armed && vin) |=>
      state == cfg_loader_pkg::ST_LOAD_FUSE ##1 FUSE_RD_EN)
    else $error("fuse load not started");

  a_none_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
    (state == cfg_loader_pkg::ST_SELECT && !sel_pin && !keep &&
     !fuse_sel && vin) |=>
      in_ready && src == cfg_loader_pkg::SRC_NONE)
    else $error("store not left at zero");

  // Only a host write may touch the store right after a kept start
  a_keep_path: assert property (@(posedge MCLK) disable iff (!RESETN)
    (state == cfg_loader_pkg::ST_IDLE && vin_rise && keep_path) |=>
      in_ready && (!mem_wr || wr_host))
    else $error("staged contents overwritten");

  a_start_gate: assert property (@(posedge MCLK) disable iff (!RESETN)
    START_SEQ |->
      $past(in_ready && vin &&
            (keep_path || src != cfg_loader_pkg::SRC_NONE), 1))
    else $error("start without ready store");

  a_fuse_write: assert property (@(posedge MCLK) disable iff (!RESETN)
    FUSE_RD_EN |=> mem_wr && mem_waddr == $past(FUSE_RD_BANK))
    else $error("fuse bank not written");

endmodule : otp_config_source_loader

`default_nettype wire

/* File: verification/fuse_bank_model.sv */
// Fuse array stand-in: ten banks of 26 bits, raw and corrected views.
// Assumes reads are one bank per FUSE_RD_EN cycle on MCLK.
`timescale 1ns/1ps
`default_nettype none

module fuse_bank_model (
  input wire logic MCLK,
  input wire logic FUSE_RD_EN,
  input wire logic [3:0] FUSE_RD_BANK,
  input wire logic [3:0] word0_low,
  output logic [25:0] FUSE_RAW_DATA,
  output logic [25:0] FUSE_CORR_DATA
);
  logic [25:0] word;

  //////////////////////////////////////////////////////////////////////
  // Bank contents, word 0 carries the address nibble
  assign word = (FUSE_RD_BANK == 4'h0) ? {22'h0aaaaa, word0_low} :
                {FUSE_RD_BANK, 22'h155555};

  // Data valid the cycle after a read, scrambled otherwise
  always @(posedge MCLK) begin
    if (FUSE_RD_EN) begin
      FUSE_RAW_DATA <= word;
      FUSE_CORR_DATA <= ~word;
    end else begin
      FUSE_RAW_DATA <= ~FUSE_RAW_DATA;
      FUSE_CORR_DATA <= ~FUSE_CORR_DATA;
    end
  end
endmodule : fuse_bank_model

`default_nettype wire

/* File: verification/otp_config_source_loader_test.sv */
// Self-checking bench for the configuration loader.
// Assumes the fuse model above; oscillators made here as free pins.
`timescale 1ns/1ps
`default_nettype none

module otp_config_source_loader_test;
  logic MCLK = 0, RESETN = 0, VIN_VALID = 0, SUPPLY_SELECT_PIN = 0;
  logic POWER_BUTTON = 0, VIN_ABOVE_UV = 0, FAST_OSC = 0, SLOW_OSC = 0;
  logic ALL_SLEEP = 0, ALL_PFM = 0, ON_STATE = 0, CTRL_WR = 0;
  logic CTRL_KEEP_STAGED_CONFIG = 0, CTRL_FUSE_LOAD_SELECT = 0;
  logic CTRL_ECC_SELECT = 0, TRIM_WR = 0, HOST_WR = 0;
  logic FUSE_ECC_PROGRAMMED = 0;
  logic [9:0] CTRL_FUSE_LOAD_BITS = 0;
  logic [5:0] TRIM_WDATA = 0, TRIM_CODE;
  logic [3:0] HOST_ADDR = 0, SEQ_RD_ADDR = 0, FUSE_RD_BANK, nib = 0;
  logic [25:0] HOST_WDATA = 0, FUSE_RAW_DATA, FUSE_CORR_DATA, SEQ_RD_DATA;
  logic FUSE_RD_EN, CONFIG_READY, POWER_BUTTON_MODE, START_SEQ, TURN_OFF;
  logic TIMEBASE_TICK, DEBOUNCE_TICK, IRQ_DEBOUNCE_TICK, SWITCH_CLK;
  logic LOW_INPUT_IRQ_TICK, POWER_BUTTON_IRQ_TICK, got, swq, slq;
  logic [1:0] CONFIG_SOURCE;
  logic [3:0] TARGET_ADDR_FIELD;
  logic [6:0] TARGET_ADDR;
  logic [2:0] evt;
  int error_cnt = 0, n_compared = 0, c, i, nsw, nsl, nlo, nir, nt, np;

  otp_config_source_loader #(.HOLD_TICKS(4)) u_otp_config_source_loader (
    .MCLK, .RESETN, .VIN_VALID, .SUPPLY_SELECT_PIN, .POWER_BUTTON,
    .VIN_ABOVE_UV, .FAST_OSC, .SLOW_OSC, .ALL_SLEEP, .ALL_PFM, .ON_STATE,
    .CTRL_WR, .CTRL_KEEP_STAGED_CONFIG, .CTRL_FUSE_LOAD_SELECT,
    .CTRL_ECC_SELECT, .CTRL_FUSE_LOAD_BITS, .TRIM_WR, .TRIM_WDATA,
    .TRIM_CODE, .HOST_WR, .HOST_ADDR, .HOST_WDATA, .FUSE_RD_EN,
    .FUSE_RD_BANK, .FUSE_RAW_DATA, .FUSE_CORR_DATA, .FUSE_ECC_PROGRAMMED,
    .SEQ_RD_ADDR, .SEQ_RD_DATA, .CONFIG_READY, .CONFIG_SOURCE,
    .TARGET_ADDR_FIELD, .TARGET_ADDR, .POWER_BUTTON_MODE, .START_SEQ,
    .TURN_OFF, .TIMEBASE_TICK, .DEBOUNCE_TICK, .IRQ_DEBOUNCE_TICK,
    .LOW_INPUT_IRQ_TICK, .POWER_BUTTON_IRQ_TICK, .SWITCH_CLK);

  fuse_bank_model u_fuse_bank_model (.MCLK, .FUSE_RD_EN, .FUSE_RD_BANK,
    .word0_low(nib), .FUSE_RAW_DATA, .FUSE_CORR_DATA);

  // Events waited on by index
  assign evt = {TURN_OFF, START_SEQ, CONFIG_READY};

  //////////////////////////////////////////////////////////////////////
  // Core clock, 16 MHz and untrimmed slow oscillator pins
  initial begin
    forever #10 MCLK = ~MCLK;
  end
  initial begin
    forever #31.25 FAST_OSC = ~FAST_OSC;
  end
  initial begin
    forever #10000 SLOW_OSC = ~SLOW_OSC;
  end

  // Hang guard
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic waitev(input int b, input int lim, output logic g);
    g = 1'b0;
    for (int n = 0; n < lim && !g; n++) begin
      @(posedge MCLK);
      #1;
      g = (evt[b] === 1'b1);
    end
  endtask : waitev

  task automatic ctl(input logic kp, fs, ec, input logic [9:0] fb);
    @(posedge MCLK);
    CTRL_WR <= 1'b1;
    CTRL_KEEP_STAGED_CONFIG <= kp;
    CTRL_FUSE_LOAD_SELECT <= fs;
    CTRL_ECC_SELECT <= ec;
    CTRL_FUSE_LOAD_BITS <= fb;
    @(posedge MCLK);
    CTRL_WR <= 1'b0;
  endtask : ctl

  task automatic hw(input logic [3:0] a, input logic [25:0] d);
    @(posedge MCLK);
    HOST_WR <= 1'b1;
    HOST_ADDR <= a;
    HOST_WDATA <= d;
    @(posedge MCLK);
    HOST_WR <= 1'b0;
  endtask : hw

  task automatic rd(input logic [3:0] a, input logic [25:0] e);
    @(posedge MCLK);
    SEQ_RD_ADDR <= a;
    repeat (2) @(posedge MCLK);
    #1;
    chk("word", SEQ_RD_DATA, e);
  endtask : rd

  // Supply cycle with the select pin, then wait for the load
  task automatic pu(input logic sel, input logic [1:0] src);
    logic g;
    @(posedge MCLK);
    VIN_VALID <= 1'b0;
    SUPPLY_SELECT_PIN <= sel;
    repeat (8) @(posedge MCLK);
    VIN_VALID <= 1'b1;
    waitev(0, 80, g);
    chk("ready", g, 1'b1);
    chk("source", CONFIG_SOURCE, src);
  endtask : pu

  // All ten words: 0 raw fuse, 1 corrected fuse, 2 zero
  task automatic rdall(input int m);
    logic [25:0] w;
    for (int k = 0; k < 10; k++) begin
      w = (k == 0) ? {22'h0aaaaa, nib} : {4'(k), 22'h155555};
      rd(4'(k), (m == 2) ? 26'h0 : (m == 1) ? ~w : w);
    end
  endtask : rdall

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge MCLK);
    RESETN <= 1'b1;
    @(posedge MCLK);
    #1;
    chk("trim", TRIM_CODE, 6'h20);
    chk("addr", TARGET_ADDR, 7'h08);
    @(posedge MCLK);
    TRIM_WR <= 1'b1;
    TRIM_WDATA <= 6'h15;
    @(posedge MCLK);
    TRIM_WR <= 1'b0;
    @(posedge MCLK);
    #1;
    chk("trim", TRIM_CODE, 6'h15);
    pu(1'b0, 2'h0);
    ctl(1'b1, 1'b1, 1'b0, 10'h3ff);
    pu(1'b1, 2'h3);
    rd(4'h0, cfg_loader_pkg::DEF_CFG);
    rd(4'h9, cfg_loader_pkg::DEF_OTHER);
    for (c = 0; c < 8; c++) begin
      nib = 4'(c);
      ctl(1'b0, 1'b1, 1'b0, 10'h3ff);
      pu(1'b0, 2'h1);
      chk("addr", TARGET_ADDR, 7'h08 + 7'(c));
      chk("field", TARGET_ADDR_FIELD, {1'b1, 3'(c)});
      rdall(0);
    end
    @(posedge MCLK);
    FUSE_ECC_PROGRAMMED <= 1'b1;
    ctl(1'b0, 1'b1, 1'b1, 10'h3ff);
    pu(1'b0, 2'h1);
    rdall(1);
    ctl(1'b0, 1'b1, 1'b0, 10'h3fe);
    pu(1'b0, 2'h0);
    ctl(1'b0, 1'b0, 1'b0, 10'h3ff);
    pu(1'b0, 2'h0);
    rdall(2);
    @(posedge MCLK);
    POWER_BUTTON <= 1'b1;
    waitev(1, 30, got);
    chk("start", got, 1'b0);
    @(posedge MCLK);
    POWER_BUTTON <= 1'b0;
    hw(4'h2, 26'h1234567);
    rd(4'h2, 26'h1234567);
    @(posedge MCLK);
    VIN_VALID <= 1'b0;
    repeat (8) @(posedge MCLK);
    hw(4'h3, 26'h0abcdef);
    ctl(1'b1, 1'b0, 1'b0, 10'h000);
    pu(1'b0, 2'h2);
    rd(4'h2, 26'h1234567);
    rd(4'h3, 26'h0);
    @(posedge MCLK);
    POWER_BUTTON <= 1'b1;
    waitev(1, 30, got);
    chk("start", got, 1'b1);
    @(posedge MCLK);
    POWER_BUTTON <= 1'b1;
    nib = 4'hd;
    ctl(1'b0, 1'b1, 1'b0, 10'h3ff);
    pu(1'b0, 2'h1);
    chk("mode", POWER_BUTTON_MODE, 1'b1);
    chk("addr", TARGET_ADDR, 7'h0d);
    @(posedge MCLK);
    POWER_BUTTON <= 1'b0;
    waitev(1, 30, got);
    chk("start", got, 1'b1);
    waitev(2, 6000, got);
    chk("early off", got, 1'b0);
    waitev(2, 3000, got);
    chk("off", got, 1'b1);
    @(posedge MCLK);
    ON_STATE <= 1'b1;
    VIN_ABOVE_UV <= 1'b1;
    {nsw, nsl, nlo, nir, nt, np, swq, slq} = '0;
    for (i = 0; i < 10000; i++) begin
      @(posedge MCLK);
      #1;
      nsw += int'(SWITCH_CLK && !swq);
      swq = SWITCH_CLK;
      nsl += int'(SLOW_OSC && !slq);
      slq = SLOW_OSC;
      nlo += int'(LOW_INPUT_IRQ_TICK === 1'b1);
      nir += int'(IRQ_DEBOUNCE_TICK === 1'b1);
      nt += int'(TIMEBASE_TICK === 1'b1);
      np += int'(POWER_BUTTON_IRQ_TICK === 1'b1);
    end
    chk("swclk", nsw >= 399 && nsw <= 401, 1'b1);
    chk("lowirq", nlo + 1 >= nsl && nlo <= nsl + 1, 1'b1);
    chk("irqtick", nir >= 5 && nir <= 7, 1'b1);
    chk("timebase", nt >= 5 && nt <= 7, 1'b1);
    chk("btnirq", np + 1 >= nsl && np <= nsl + 1, 1'b1);
    end_of_test();
  end
endmodule : otp_config_source_loader_test

`default_nettype wire
